/* rtl/tpmt_defs.svh */
// constants for the touch panel measurement timing block
// assumes a 100 MHz reference clock and 8-bit register writes
`ifndef TPMT_DEFS_SVH
`define TPMT_DEFS_SVH

// ==========================================================
// register offsets and reset values
`define TPMT_PSU_ADDR       8'h05
`define TPMT_DCV_ADDR       8'h06
`define TPMT_PULLUP_ADDR    8'h07
`define TPMT_CFG_RESET      8'h00

// ==========================================================
// field positions: position code high nibble, pressure low
`define TPMT_HI_MSB         7
`define TPMT_HI_LSB         4
`define TPMT_LO_MSB         3
`define TPMT_LO_LSB         0

// ==========================================================
// clock period in nanoseconds, ladder times in microseconds
`define TPMT_CLK_PERIOD_NS  10
`define TPMT_NS_PER_US      1000
`define TPMT_PSU_SKIP_US    0
`define TPMT_STD_US0        10
`define TPMT_STD_US1        20
`define TPMT_STD_US2        50
`define TPMT_STD_US3        80
`define TPMT_STD_US4        100
`define TPMT_STD_US5        200
`define TPMT_STD_US6        500
`define TPMT_STD_US7        800
`define TPMT_ROUGH_US0      2
`define TPMT_ROUGH_US1      3
`define TPMT_ROUGH_US2      4
`define TPMT_ROUGH_US3      5
`define TPMT_ROUGH_US4      10
`define TPMT_ROUGH_US5      50
`define TPMT_ROUGH_US6      100
`define TPMT_ROUGH_US7      500
`define TPMT_MS_US8         1000
`define TPMT_MS_US9         2000
`define TPMT_MS_US10        5000
`define TPMT_MS_US11        10000
`define TPMT_MS_US12        20000
`define TPMT_MS_US13        50000
`define TPMT_MS_US14        100000
`define TPMT_MS_US15        200000

`endif

/* rtl/tpmt_pkg.sv */
// types and the interval ladder decode for the measurement timing block
// assumes tpmt_defs.svh is on the include path
`include "tpmt_defs.svh"

package tpmt_pkg;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      TPMT_LAD_PSU   = 2'b00,
      TPMT_LAD_STD   = 2'b01,
      TPMT_LAD_ROUGH = 2'b10
   } tpmt_ladder_e;

   typedef enum logic [2:0] {
      TPMT_IDLE   = 3'b000,
      TPMT_PSU    = 3'b001,
      TPMT_DCV    = 3'b010,
      TPMT_SAMPLE = 3'b011,
      TPMT_PUR    = 3'b100,
      TPMT_PUF    = 3'b101
   } tpmt_state_e;

   typedef logic [31:0] tpmt_cyc_t;

   // ==========================================================
   // code to microseconds, shared upper half for all ladders
   function automatic tpmt_cyc_t tpmt_ladder_us(input logic [3:0]   code,
                                                 input tpmt_ladder_e lad);
      tpmt_cyc_t lo;
      tpmt_cyc_t us;
      lo = 32'h0;
      us = 32'h0;
      case (code[2:0])
         3'h0: lo = (lad == TPMT_LAD_ROUGH) ? `TPMT_ROUGH_US0 :
                    (lad == TPMT_LAD_PSU) ? `TPMT_PSU_SKIP_US : `TPMT_STD_US0;
         3'h1: lo = (lad == TPMT_LAD_ROUGH) ? `TPMT_ROUGH_US1 : `TPMT_STD_US1;
         3'h2: lo = (lad == TPMT_LAD_ROUGH) ? `TPMT_ROUGH_US2 : `TPMT_STD_US2;
         3'h3: lo = (lad == TPMT_LAD_ROUGH) ? `TPMT_ROUGH_US3 : `TPMT_STD_US3;
         3'h4: lo = (lad == TPMT_LAD_ROUGH) ? `TPMT_ROUGH_US4 : `TPMT_STD_US4;
         3'h5: lo = (lad == TPMT_LAD_ROUGH) ? `TPMT_ROUGH_US5 : `TPMT_STD_US5;
         3'h6: lo = (lad == TPMT_LAD_ROUGH) ? `TPMT_ROUGH_US6 : `TPMT_STD_US6;
         default: lo = (lad == TPMT_LAD_ROUGH) ? `TPMT_ROUGH_US7 : `TPMT_STD_US7;
      endcase
      case (code)
         4'h8: us = `TPMT_MS_US8;
         4'h9: us = `TPMT_MS_US9;
         4'hA: us = `TPMT_MS_US10;
         4'hB: us = `TPMT_MS_US11;
         4'hC: us = `TPMT_MS_US12;
         4'hD: us = `TPMT_MS_US13;
         4'hE: us = `TPMT_MS_US14;
         4'hF: us = `TPMT_MS_US15;
         default: us = lo;
      endcase
      return us;
   endfunction

   // never less than one cycle
   function automatic tpmt_cyc_t tpmt_ladder_cyc(input logic [3:0]   code,
                                                  input tpmt_ladder_e lad,
                                                  input tpmt_cyc_t    cyc_per_us);
      tpmt_cyc_t c;
      c = 32'(tpmt_ladder_us(code, lad) * cyc_per_us);
      return (c == 32'h0) ? 32'h1 : c;
   endfunction

endpackage

/* rtl/tpmt_interval_timer.sv */
// down counter that times one sequencer interval
// assumes load is a single-cycle pulse from the same clock
`timescale 1ns/1ps

module tpmt_interval_timer
   import tpmt_pkg::*;
(
   input  wire logic      ref_clk,
   input  wire logic      reset_n,
   input  wire logic      load,
   input  wire tpmt_cyc_t len_cyc,
   output logic           done
);

   // ==========================================================
   // counter: done fires len_cyc cycles after load
   tpmt_cyc_t cnt_r;
   logic      run_r;

   // no load term: load is decoded from the next state, which reads done
   assign done = run_r && (cnt_r == 32'h0);

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         cnt_r <= 32'h0;
         run_r <= 1'b0;
      end else if (load) begin
         cnt_r <= len_cyc - 32'h1;
         run_r <= 1'b1;
      end else if (run_r) begin
         if (cnt_r == 32'h0) begin
            run_r <= 1'b0;
         end else begin
            cnt_r <= cnt_r - 32'h1;
         end
      end
   end

endmodule

/* rtl/tpmt_sequencer.sv */
// measurement timing sequencer: config registers, interval ladders, panel/adc steering
// assumes start and adc_done come from logic on ref_clk; adc_done is a pulse
//
// Functional notes
// - panel setup code ladder 0us..800us then 1ms..200ms, same for pressure.
// - panel setup precedes every measurement, combined command and autonomous scan.
// - during panel setup the panel is configured and the adc is off.
// - panel setup code zero skips the interval; host uses it for fast panels.
// - adc settle code ladder 10us..800us then 1ms..200ms, same for pressure.
// - during adc settle the panel stays configured and the adc is powered.
// - rough pullup ladder from 2us, codes 1000..1111 give 1ms..200ms.
// - fine pullup ladder 10us..800us then 1ms..200ms.
// - rough and fine pullups follow each command except continuous direct conversions.
// - rough code for 2us leaves the rough switch open, extending fine time.
`timescale 1ns/1ps
`include "tpmt_defs.svh"

module tpmt_sequencer
   import tpmt_pkg::*;
#(
   parameter tpmt_cyc_t CYC_PER_US = 32'(`TPMT_NS_PER_US / `TPMT_CLK_PERIOD_NS)
)
(
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_addr,
   input  wire logic [7:0] wr_data,
   input  wire logic [7:0] rd_addr,
   output logic [7:0]      rd_data,
   input  wire logic       start,
   input  wire logic       pressure_sel,
   input  wire logic       continuous_conversion_bit,
   input  wire logic       adc_done,
   output logic            panel_config_en,
   output logic            adc_power_en,
   output logic            adc_sample_start,
   output logic            rough_pullup_switch,
   output logic            fine_pullup_en,
   output logic            busy,
   output logic            seq_done,
   output logic [2:0]      seq_state
);

   // ==========================================================
   // configuration registers
   logic [7:0] psu_cfg_r;
   logic [7:0] dcv_cfg_r;
   logic [7:0] pull_cfg_r;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         psu_cfg_r  <= `TPMT_CFG_RESET;
         dcv_cfg_r  <= `TPMT_CFG_RESET;
         pull_cfg_r <= `TPMT_CFG_RESET;
      end else if (wr_en) begin
         if (wr_addr == `TPMT_PSU_ADDR) psu_cfg_r <= wr_data;
         if (wr_addr == `TPMT_DCV_ADDR) dcv_cfg_r <= wr_data;
         if (wr_addr == `TPMT_PULLUP_ADDR) pull_cfg_r <= wr_data;
      end
   end

   // unmapped offsets read as zero
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         rd_data <= 8'h00;
      end else begin
         case (rd_addr)
            `TPMT_PSU_ADDR:    rd_data <= psu_cfg_r;
            `TPMT_DCV_ADDR:    rd_data <= dcv_cfg_r;
            `TPMT_PULLUP_ADDR: rd_data <= pull_cfg_r;
            default:           rd_data <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // pressure select and continuous bit latched at start; the codes are read live from the config registers
   tpmt_state_e state_r;
   tpmt_state_e state_nxt;
   logic        press_r;
   logic        continuous_conversion_bit_r;
   logic [3:0]  psu_code;
   logic [3:0]  dcv_code;
   logic [3:0]  start_psu_code;
   logic [3:0]  rough_code;
   logic [3:0]  fine_code;

   assign rough_code = pull_cfg_r[`TPMT_HI_MSB:`TPMT_HI_LSB];
   assign fine_code  = pull_cfg_r[`TPMT_LO_MSB:`TPMT_LO_LSB];
   assign psu_code   = press_r ? psu_cfg_r[`TPMT_LO_MSB:`TPMT_LO_LSB]
                               : psu_cfg_r[`TPMT_HI_MSB:`TPMT_HI_LSB];
   assign dcv_code   = press_r ? dcv_cfg_r[`TPMT_LO_MSB:`TPMT_LO_LSB]
                               : dcv_cfg_r[`TPMT_HI_MSB:`TPMT_HI_LSB];
   assign start_psu_code = pressure_sel ? psu_cfg_r[`TPMT_LO_MSB:`TPMT_LO_LSB]
                                        : psu_cfg_r[`TPMT_HI_MSB:`TPMT_HI_LSB];

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         press_r <= 1'b0;
         continuous_conversion_bit_r  <= 1'b0;
      end else if (state_r == TPMT_IDLE && start) begin
         press_r <= pressure_sel;
         continuous_conversion_bit_r  <= continuous_conversion_bit;
      end
   end

   // ==========================================================
   // interval timer and its load length
   logic      tmr_load;
   logic      tmr_done;
   tpmt_cyc_t tmr_len;

   always_comb begin
      tmr_load = 1'b0;
      tmr_len  = 32'h1;
      case (state_nxt)
         TPMT_PSU: tmr_len = tpmt_ladder_cyc(start_psu_code, TPMT_LAD_PSU, CYC_PER_US);
         TPMT_DCV: tmr_len = tpmt_ladder_cyc(state_r == TPMT_IDLE ? dcv_cfg_r[
                                (pressure_sel ? `TPMT_LO_MSB : `TPMT_HI_MSB) -: 4] : dcv_code,
                                TPMT_LAD_STD, CYC_PER_US);
         TPMT_PUR: tmr_len = tpmt_ladder_cyc(rough_code, TPMT_LAD_ROUGH, CYC_PER_US);
         TPMT_PUF: tmr_len = tpmt_ladder_cyc(fine_code, TPMT_LAD_STD, CYC_PER_US);
         default:  tmr_len = 32'h1;
      endcase
      if (state_nxt != state_r && state_nxt != TPMT_IDLE && state_nxt != TPMT_SAMPLE) begin
         tmr_load = 1'b1;
      end
   end

   tpmt_interval_timer u_timer (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .load    (tmr_load),
      .len_cyc (tmr_len),
      .done    (tmr_done)
   );

   // ==========================================================
   // sequencer state machine
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         TPMT_IDLE: begin
            // setup first; code zero skips it
            if (start) begin
               state_nxt = (start_psu_code == 4'h0) ? TPMT_DCV : TPMT_PSU;
            end
         end
         TPMT_PSU:    if (tmr_done) state_nxt = TPMT_DCV;
         TPMT_DCV:    if (tmr_done) state_nxt = TPMT_SAMPLE;
         TPMT_SAMPLE: begin
            // continuous direct conversions skip the pullups
            if (adc_done) state_nxt = continuous_conversion_bit_r ? TPMT_IDLE : TPMT_PUR;
         end
         TPMT_PUR:    if (tmr_done) state_nxt = TPMT_PUF;
         TPMT_PUF:    if (tmr_done) state_nxt = TPMT_IDLE;
         default:     state_nxt = TPMT_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state_r <= TPMT_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         adc_sample_start <= 1'b0;
         seq_done         <= 1'b0;
      end else begin
         adc_sample_start <= (state_r == TPMT_DCV) && tmr_done;
         seq_done         <= (state_r != TPMT_IDLE) && (state_nxt == TPMT_IDLE);
      end
   end

   // ==========================================================
   // panel and adc steering, decoded from the state flops
   // panel set up with adc off during setup
   // panel and adc both on during settle
   assign panel_config_en = (state_r == TPMT_PSU) || (state_r == TPMT_DCV) ||
                            (state_r == TPMT_SAMPLE);
   assign adc_power_en    = (state_r == TPMT_DCV) || (state_r == TPMT_SAMPLE);
   // shortest rough setting keeps the switch open to save power
   assign rough_pullup_switch = (state_r == TPMT_PUR) && (rough_code != 4'h0);
   assign fine_pullup_en  = (state_r == TPMT_PUF) ||
                            ((state_r == TPMT_PUR) && (rough_code == 4'h0));
   assign busy            = (state_r != TPMT_IDLE);
   assign seq_state       = state_r;

   // ==========================================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   tpmt_cyc_t dcv_cnt_r;
   always_ff @(posedge ref_clk) begin
      if (!reset_n) dcv_cnt_r <= 32'h0;
      else if (state_r == TPMT_DCV) dcv_cnt_r <= dcv_cnt_r + 32'h1;
      else dcv_cnt_r <= 32'h0;
   end

   psu_adc_off_a: assert property (
      state_r == TPMT_PSU |-> panel_config_en && !adc_power_en)
      else $error("adc powered during panel setup");
   psu_first_a: assert property (
      state_r == TPMT_IDLE && start && start_psu_code != 4'h0 |=> state_r == TPMT_PSU)
      else $error("panel setup not entered on start");
   psu_skip_a: assert property (
      state_r == TPMT_IDLE && start && start_psu_code == 4'h0 |=> state_r == TPMT_DCV)
      else $error("skip mode did not bypass panel setup");
   dcv_power_a: assert property (
      state_r == TPMT_DCV |-> panel_config_en && adc_power_en)
      else $error("panel or adc off during settle");
   dcv_len_a: assert property (
      state_r == TPMT_DCV && state_nxt != TPMT_DCV |->
         dcv_cnt_r + 32'h1 == tpmt_ladder_cyc(dcv_code, TPMT_LAD_STD, CYC_PER_US))
      else $error("settle interval length wrong");
   sample_order_a: assert property (
      state_r == TPMT_DCV && tmr_done |=> adc_sample_start && state_r == TPMT_SAMPLE)
      else $error("sampling not started after settle");
   pullup_follow_a: assert property (
      state_r == TPMT_SAMPLE && adc_done && !continuous_conversion_bit_r |=> state_r == TPMT_PUR ##0
         rough_pullup_switch == (rough_code != 4'h0))
      else $error("pullup interval missing after measurement");
   continuous_conversion_bit_skip_a: assert property (
      state_r == TPMT_SAMPLE && adc_done && continuous_conversion_bit_r |=> state_r == TPMT_IDLE ##0 seq_done)
      else $error("continuous conversion entered pullups");
   rough_min_a: assert property (
      state_r == TPMT_PUR && rough_code == 4'h0 |-> !rough_pullup_switch && fine_pullup_en)
      else $error("rough switch engaged at minimum setting");

   full_seq_c: cover property (state_r == TPMT_PUF && tmr_done ##1 seq_done);
   skip_seq_c: cover property (state_r == TPMT_IDLE && start && start_psu_code == 4'h0);
   continuous_conversion_bit_seq_c: cover property (state_r == TPMT_SAMPLE && adc_done && continuous_conversion_bit_r);
   rough_min_c: cover property (state_r == TPMT_PUR && rough_code == 4'h0);

endmodule

/* testbench/tpmt_panel_model.sv */
// panel and adc stand-in: answers each sampling request after a set delay
// assumes the sequencer's sample pulse and power level on the same ref_clk
`timescale 1ns/1ps

module tpmt_panel_model (
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       adc_power_en,
   input  wire logic       adc_sample_start,
   input  wire logic [7:0] dly,
   input  wire logic       glitch,
   output logic            adc_done
);
   // ==========================================================
   // conversion timing
   logic [8:0] wait_r;

   // converts only when powered
   // an unpowered request never finishes, so the run hangs visibly
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         wait_r   <= 9'h0;
         adc_done <= 1'b0;
      end else begin
         adc_done <= glitch || (wait_r == 9'h1);
         if (adc_sample_start && adc_power_en) begin
            wait_r <= {1'b0, dly};
         end else if (wait_r != 9'h0) begin
            wait_r <= wait_r - 9'h1;
         end
      end
   end
endmodule

/* testbench/test_touch_panel_measurement_timing.sv */
// self-checking bench for the measurement timing sequencer
// assumes rtl package, header and the panel model are compiled first
`timescale 1ns/1ps

module test_touch_panel_measurement_timing;
   // ==========================================================
   // signals and scoreboard
   typedef struct {
      int   panel_settle_time_config;
      int   dcv;
      int   rough_pullup_interval;
      int   fine_pullup_interval;
      int   smp;
      int   lvl;
      logic rc;
   } tpmt_obs_s;

   localparam int STD_US[8]   = '{10, 20, 50, 80, 100, 200, 500, 800};
   localparam int ROUGH_US[8] = '{2, 3, 4, 5, 10, 50, 100, 500};
   localparam int MS_US[8]    = '{1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000};

   logic       ref_clk, reset_n, wr_en, start, pressure_sel, continuous_conversion_bit_bit, adc_done, glitch;
   logic [7:0] wr_addr, wr_data, rd_addr, rd_data, dly, v;
   logic       panel_config_en, adc_power_en, adc_sample_start, rough_pullup_switch;
   logic       fine_pullup_en, busy, seq_done;
   logic [2:0] seq_state;
   int         fails, cmp_count, i;
   tpmt_obs_s  obs, e;
   tpmt_obs_s  exp_q[$];

   tpmt_sequencer #(.CYC_PER_US(32'h1)) u_tpmt_sequencer (
      .ref_clk(ref_clk), .reset_n(reset_n), .wr_en(wr_en), .wr_addr(wr_addr),
      .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data), .start(start),
      .pressure_sel(pressure_sel), .continuous_conversion_bit(continuous_conversion_bit_bit),
      .adc_done(adc_done), .panel_config_en(panel_config_en),
      .adc_power_en(adc_power_en), .adc_sample_start(adc_sample_start),
      .rough_pullup_switch(rough_pullup_switch), .fine_pullup_en(fine_pullup_en),
      .busy(busy), .seq_done(seq_done), .seq_state(seq_state));

   tpmt_panel_model u_tpmt_panel_model (
      .ref_clk(ref_clk), .reset_n(reset_n), .adc_power_en(adc_power_en),
      .adc_sample_start(adc_sample_start), .dly(dly), .glitch(glitch),
      .adc_done(adc_done));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ==========================================================
   // helpers
   task automatic chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         fails++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   function automatic int lad(input logic [3:0] c, input int kind);
      if (c[3]) return MS_US[c[2:0]];
      if (kind == 0 && c == 4'h0) return 0;
      return (kind == 2) ? ROUGH_US[c[2:0]] : STD_US[c[2:0]];
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      wr_en   <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      @(posedge ref_clk);
      rd_addr <= a;
      @(posedge ref_clk);
      #1 chk(rd_data === x, "register read");
   endtask

   // one measurement; a second start and a stray done are thrown in mid-run
   task automatic run(input logic [3:0] pc, input logic [3:0] dc, input logic [3:0] rg,
                      input logic [3:0] fc, input logic ps, input logic ct,
                      input logic [7:0] dl);
      tpmt_obs_s x;
      logic [3:0] r4;
      int n;
      r4 = 4'($urandom);
      wr(8'h05, ps ? {r4, pc} : {pc, r4});
      wr(8'h06, ps ? {r4, dc} : {dc, r4});
      wr(8'h07, {rg, fc});
      x = '{panel_settle_time_config: lad(pc, 0), dcv: lad(dc, 1), rough_pullup_interval: ct ? 0 : lad(rg, 2),
            fine_pullup_interval: ct ? 0 : lad(fc, 1), smp: 1, lvl: 0, rc: !ct && rg != 4'h0};
      exp_q.push_back(x);
      @(posedge ref_clk);
      dly          <= dl;
      start        <= 1'b1;
      pressure_sel <= ps;
      continuous_conversion_bit_bit     <= ct;
      @(posedge ref_clk);
      start <= 1'b0;
      repeat (2) @(posedge ref_clk);
      start  <= 1'b1;
      glitch <= 1'b1;
      @(posedge ref_clk);
      start  <= 1'b0;
      glitch <= 1'b0;
      for (n = 0; n < 30000 && seq_done !== 1'b1; n++) @(negedge ref_clk);
      chk(n < 30000, "run did not finish");
      @(posedge ref_clk);
   endtask

   // ==========================================================
   // watcher: measures each interval, compares at seq_done
   always @(negedge ref_clk) begin
      if (seq_state === 3'h1) begin
         obs.panel_settle_time_config++;
         if (!(panel_config_en === 1'b1 && adc_power_en === 1'b0)) obs.lvl++;
      end
      if (seq_state === 3'h2) begin
         obs.dcv++;
         if (!(panel_config_en === 1'b1 && adc_power_en === 1'b1)) obs.lvl++;
      end
      if (seq_state === 3'h4) begin
         obs.rough_pullup_interval++;
         obs.rc = obs.rc | rough_pullup_switch;
         // open rough switch leaves fine pullup on
         if (rough_pullup_switch === 1'b0 && fine_pullup_en !== 1'b1) obs.lvl++;
      end
      if (seq_state === 3'h5) begin
         obs.fine_pullup_interval++;
         // fine pullup alone during its interval
         if (fine_pullup_en !== 1'b1 || rough_pullup_switch !== 1'b0) obs.lvl++;
      end
      if (busy !== (seq_state !== 3'h0)) obs.lvl++;
      // idle: panel, adc and pullups all released
      if (seq_state === 3'h0 && (panel_config_en || adc_power_en || rough_pullup_switch ||
                                 fine_pullup_en) !== 1'b0) obs.lvl++;
      if (adc_sample_start === 1'b1) obs.smp += (seq_state === 3'h3) ? 1 : 10;
      if (seq_done === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk(1'b0, "run end with nothing expected");
         end else begin
            e = exp_q.pop_front();
            chk(obs.panel_settle_time_config == e.panel_settle_time_config && obs.dcv == e.dcv && obs.rough_pullup_interval == e.rough_pullup_interval, "interval");
            chk(obs.fine_pullup_interval == e.fine_pullup_interval && obs.rc === e.rc && obs.smp == 1, "pullup");
            chk(obs.lvl == 0, "panel or adc level");
         end
         obs = '{default: 0};
      end
   end

   initial begin
      // roughly three times the cycles the scenarios need
      repeat (40000) @(posedge ref_clk);
      fails++;
      $display("BAD %0t watchdog expired", $time);
      summarize();
   end

   // ==========================================================
   // main sequence
   initial begin
      reset_n      = 1'b0;
      wr_en        = 1'b0;
      wr_addr      = 8'h00;
      wr_data      = 8'h00;
      rd_addr      = 8'h00;
      start        = 1'b0;
      pressure_sel = 1'b0;
      continuous_conversion_bit_bit     = 1'b0;
      glitch       = 1'b0;
      dly          = 8'h01;
      obs          = '{default: 0};
      void'($urandom(31510));
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      for (i = 5; i < 9; i++) rd(8'(i), 8'h00);
      $display("test reset values done");
      for (i = 5; i < 9; i++) begin
         v = 8'($urandom);
         wr(8'(i), v);
         rd(8'(i), (i == 8) ? 8'h00 : v);
      end
      $display("test register access done");
      // mid-run reset: state and registers return to zero
      wr(8'h05, 8'h40);
      @(posedge ref_clk);
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 chk(busy === 1'b1 && seq_state === 3'h1, "busy in setup");
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      obs = '{default: 0};
      #1 chk(busy === 1'b0 && seq_state === 3'h0 && panel_config_en === 1'b0, "reset");
      rd(8'h05, 8'h00);
      $display("test mid-run reset done");
      for (i = 0; i < 8; i++) begin
         run(4'(i), 4'(i), 4'(i), 4'(i), 1'($urandom), 1'b0, 8'($urandom_range(1, 40)));
      end
      $display("test low ladder codes done");
      run(4'h8, 4'h0, 4'h0, 4'h9, 1'b0, 1'b0, 8'h01);
      // host picks skip again, now with long settle and a slow adc answer
      run(4'h0, 4'h8, 4'h8, 4'h0, 1'b1, 1'b0, 8'hC8);
      run(4'h3, 4'h2, 4'h5, 4'h6, 1'b1, 1'b1, 8'h03);
      $display("test long codes and continuous done");
      chk(exp_q.size() == 0, "results left unchecked");
      summarize();
   end
endmodule
